/* File: fbo_pkg.sv */
// Constants, field layouts and types shared by the flash bus-operation logic
package fbo_pkg;
   localparam int ADDR_W = 21;
   localparam int DATA_W = 16;
   localparam int UPPER_W = 5;
   localparam int CFG_W = 16;
   ////////////////////////////////////////////////////////////////////////////
   // Configuration word layout
   localparam int CFG_READ_MODE_SELECT_BIT = 15;
   localparam int CFG_BUS_INVERSION_BIT = 14;
   localparam int CFG_BURST_LATENCY_FIELD_HI = 13;
   localparam int CFG_BURST_LATENCY_FIELD_LO = 11;
   localparam int CFG_POWERDOWN_ALLOW_BIT = 10;
   localparam int CFG_BURST_ORDER_BIT = 7;
   localparam int CFG_CLK_EDGE_BIT = 6;
   localparam int CFG_BURST_LEN_HI = 2;
   localparam int CFG_BURST_LEN_LO = 0;
   localparam logic [CFG_W-1:0] CFG_RESET = 16'h9000;
   localparam logic [2:0] BURST_LEN_4 = 3'h1;
   localparam logic [2:0] BURST_LEN_8 = 3'h2;
   localparam logic [2:0] LAT_MIN = 3'h2;
   localparam logic [2:0] LAT_MAX = 3'h6;
   ////////////////////////////////////////////////////////////////////////////
   // Identification reads, page size, burst boundary and bank split
   localparam logic [7:0] ID_MAKER_ADDR = 8'h00;
   localparam logic [7:0] ID_PART_ADDR = 8'h01;
   localparam logic [7:0] ID_BLOCK_ADDR = 8'h02;
   localparam int PAGE_WORDS = 4;
   localparam int BOUNDARY_BITS = 5;
   localparam logic [ADDR_W-1:0] BANK_B_BASE = 21'h080000;
   ////////////////////////////////////////////////////////////////////////////
   // Timing and burst states
   localparam int CLK_PERIOD_NS = 8;
   localparam int AUTO_STANDBY_NS = 150;
   localparam int AUTO_STANDBY_CYC = (AUTO_STANDBY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   typedef enum logic [2:0] {BS_IDLE, BS_LAT, BS_DATA, BS_WAIT, BS_DONE} fbo_burst_t;
endpackage

/* File: fbo_sync.sv */
// Two-flop synchroniser for a group of pin levels
`timescale 1ns/1ps
module fbo_sync #(
   parameter int W = 1
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_q;
   // First stage feeds only the second stage
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         meta_q <= {W{1'b1}};
         q <= {W{1'b1}};
      end else begin
         meta_q <= d;
         q <= meta_q;
      end
   end
endmodule // fbo_sync

/* File: fbo_flash_bus_ops.sv */
// Bus-operation logic of a dual-bank multiplexed-bus flash device
`timescale 1ns/1ps
module fbo_flash_bus_ops #(
   parameter int BLK_W = 6,
   parameter logic [15:0] MAKER_CODE = 16'h0011,
   parameter logic [15:0] PART_CODE = 16'h0022
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic chip_en_n,
   input wire logic out_en_n,
   input wire logic wr_en_n,
   input wire logic latch_en_n,
   input wire logic burst_clk,
   input wire logic hard_reset_pwrdn_n,
   input wire logic write_guard_n,
   input wire logic [fbo_pkg::UPPER_W-1:0] upper_address_lines,
   input wire logic [fbo_pkg::DATA_W-1:0] muxed_addr_data_bus_in,
   output logic [fbo_pkg::DATA_W-1:0] muxed_addr_data_bus_out,
   output logic muxed_addr_data_bus_oe,
   input wire logic bus_inversion_flag_in,
   output logic bus_inversion_flag_out,
   output logic bus_inversion_flag_oe,
   output logic wait_out,
   output logic wait_oe,
   output logic [fbo_pkg::ADDR_W-1:0] arr_addr,
   input wire logic [fbo_pkg::DATA_W-1:0] arr_data,
   input wire logic id_mode,
   input wire logic pe_busy,
   input wire logic pe_bank,
   input wire logic [fbo_pkg::DATA_W-1:0] status_word,
   input wire logic cfg_wr,
   input wire logic [fbo_pkg::CFG_W-1:0] cfg_wdata,
   output logic [fbo_pkg::CFG_W-1:0] cfg_value,
   input wire logic blk_protect,
   input wire logic blk_unprotect,
   input wire logic blk_lock,
   input wire logic pe_req,
   output logic pe_grant,
   output logic pe_refused,
   output logic unprot_refused,
   output logic wr_strobe,
   output logic [fbo_pkg::ADDR_W-1:0] wr_addr,
   output logic [fbo_pkg::DATA_W-1:0] wr_data,
   output logic standby,
   output logic pseudo_standby,
   output logic powerdown
);
   import fbo_pkg::*;
   localparam int SW = 8 + DATA_W + UPPER_W;
   localparam int NBLK = 1 << BLK_W;

   // Decodes the word address of burst step i from start s
   function automatic logic [ADDR_W-1:0] seq_addr(input logic [ADDR_W-1:0] s, input logic [ADDR_W-1:0] i,
                                                  input logic [2:0] len, input logic ilv);
      seq_addr = s + i;
      if (len == BURST_LEN_4) begin
         seq_addr = {s[ADDR_W-1:2], ilv ? (s[1:0] ^ i[1:0]) : (s[1:0] + i[1:0])};
      end else if (len == BURST_LEN_8) begin
         seq_addr = {s[ADDR_W-1:3], ilv ? (s[2:0] ^ i[2:0]) : (s[2:0] + i[2:0])};
      end
   endfunction

   // Counts the bits set in a word
   function automatic logic [4:0] ones(input logic [DATA_W-1:0] v);
      ones = 5'h00;
      for (int b = 0; b < DATA_W; b++) begin
         ones = ones + {4'h0, v[b]};
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisation; every pin is asynchronous to clk
   logic [SW-1:0] raw;
   logic [SW-1:0] syn;
   logic [SW-1:0] syn_p_q;
   assign raw = {chip_en_n, out_en_n, wr_en_n, latch_en_n, burst_clk, hard_reset_pwrdn_n, write_guard_n,
                 bus_inversion_flag_in, upper_address_lines, muxed_addr_data_bus_in};

   fbo_sync #(.W(SW)) u_sync (
      .clk(clk),
      .sys_rst(sys_rst),
      .d(raw),
      .q(syn)
   );

   // Previous sample, for edge detection and bus activity
   always_ff @(posedge clk) begin
      if (sys_rst) syn_p_q <= {SW{1'b1}};
      else syn_p_q <= syn;
   end

   logic ce_n_s, oe_n_s, we_n_s, le_n_s, k_s, rp_n_s, wg_n_s, bus_inversion_flag_s;
   logic [DATA_W-1:0] bus_s;
   logic [ADDR_W-1:0] pin_addr;
   assign bus_s = syn[DATA_W-1:0];
   assign pin_addr = syn[ADDR_W-1:0];
   assign {ce_n_s, oe_n_s, we_n_s, le_n_s, k_s, rp_n_s, wg_n_s, bus_inversion_flag_s} = syn[SW-1:ADDR_W];

   ////////////////////////////////////////////////////////////////////////////
   // Configuration word
   logic [CFG_W-1:0] cfg_q;
   logic burst_mode, ilv, bus_inversion_flag_en, pdn_en, cont_lin;
   logic [2:0] lat_raw, lat, blen;
   assign burst_mode = ~cfg_q[CFG_READ_MODE_SELECT_BIT];
   assign bus_inversion_flag_en = cfg_q[CFG_BUS_INVERSION_BIT];
   assign pdn_en = cfg_q[CFG_POWERDOWN_ALLOW_BIT];
   assign ilv = cfg_q[CFG_BURST_ORDER_BIT];
   assign blen = cfg_q[CFG_BURST_LEN_HI:CFG_BURST_LEN_LO];
   assign cont_lin = (blen != BURST_LEN_4) && (blen != BURST_LEN_8) && !ilv;
   assign lat_raw = cfg_q[CFG_BURST_LATENCY_FIELD_HI:CFG_BURST_LATENCY_FIELD_LO];
   // Out-of-range codes are clamped rather than left undefined
   assign lat = (lat_raw < LAT_MIN) ? LAT_MIN : ((lat_raw > LAT_MAX) ? LAT_MAX : lat_raw);

   // Reset pin restores read mode and inversion bits only
   always_ff @(posedge clk) begin
      if (sys_rst) cfg_q <= CFG_RESET;
      else if (!rp_n_s) begin
         cfg_q[CFG_READ_MODE_SELECT_BIT] <= CFG_RESET[CFG_READ_MODE_SELECT_BIT];
         cfg_q[CFG_BUS_INVERSION_BIT] <= CFG_RESET[CFG_BUS_INVERSION_BIT];
      end else if (cfg_wr) cfg_q <= cfg_wdata;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Address capture and edge qualification
   logic writing, k_edge, le_rise, cap;
   logic [ADDR_W-1:0] addr_q;
   assign writing = ~we_n_s | ~syn_p_q[SW-3];
   assign k_edge = ~writing & (cfg_q[CFG_CLK_EDGE_BIT] ? (k_s & ~syn_p_q[SW-5]) : (~k_s & syn_p_q[SW-5]));
   assign le_rise = le_n_s & ~syn_p_q[SW-4];
   assign cap = rp_n_s & ~ce_n_s & (le_rise | (burst_mode & ~le_n_s & k_edge));

   always_ff @(posedge clk) begin
      if (sys_rst) addr_q <= '0;
      else if (cap) addr_q <= pin_addr;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Block protection and lock table
   logic [NBLK-1:0] prot_q, lock_q;
   logic [BLK_W-1:0] cmd_blk, rd_blk;
   logic [ADDR_W-1:0] rd_addr;
   assign cmd_blk = wr_addr[ADDR_W-1 -: BLK_W];
   assign rd_addr = burst_mode ? arr_addr : addr_q;
   assign rd_blk = rd_addr[ADDR_W-1 -: BLK_W];

   generate
      for (genvar g = 0; g < NBLK; g++) begin : g_blk
         // Protect wins over unprotect issued in the same cycle
         always_ff @(posedge clk) begin
            if (sys_rst || !rp_n_s) begin
               prot_q[g] <= 1'b1;
               lock_q[g] <= 1'b0;
            end else if (cmd_blk == BLK_W'(g)) begin
               if (blk_protect) prot_q[g] <= 1'b1;
               else if (blk_unprotect && (!lock_q[g] || wg_n_s)) prot_q[g] <= 1'b0;
               if (blk_lock) lock_q[g] <= 1'b1;
            end
         end
      end
   endgenerate

   // Refusals and grants for the command logic, one cycle after the request
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         unprot_refused <= 1'b0;
         pe_grant <= 1'b0;
         pe_refused <= 1'b0;
      end else begin
         unprot_refused <= blk_unprotect & lock_q[cmd_blk] & ~wg_n_s;
         pe_refused <= pe_req & (prot_q[cmd_blk] | (lock_q[cmd_blk] & ~wg_n_s));
         pe_grant <= pe_req & ~prot_q[cmd_blk] & ~(lock_q[cmd_blk] & ~wg_n_s);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read word selection
   logic [DATA_W-1:0] page_q [PAGE_WORDS];
   logic [DATA_W-1:0] id_word, base_word, rd_word;
   logic rd_bank;
   assign rd_bank = (rd_addr >= BANK_B_BASE);
   assign id_word = (rd_addr[7:0] == ID_MAKER_ADDR) ? MAKER_CODE :
                    (rd_addr[7:0] == ID_PART_ADDR) ? PART_CODE :
                    (rd_addr[7:0] == ID_BLOCK_ADDR) ? {14'h0000, lock_q[rd_blk], prot_q[rd_blk]} : '0;
   assign base_word = burst_mode ? arr_data : page_q[addr_q[1:0]];
   // Only the bank under program shows status; the other bank reads the array
   assign rd_word = id_mode ? id_word : ((pe_busy && rd_bank == pe_bank) ? status_word : base_word);

   ////////////////////////////////////////////////////////////////////////////
   // Page buffer fill after each address capture in page mode
   logic [2:0] pg_cnt_q;
   logic pg_sv_q;
   logic [1:0] pg_si_q;
   logic pg_load;
   assign pg_load = ~pg_cnt_q[2];

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         pg_cnt_q <= 3'h4;
         pg_sv_q <= 1'b0;
         pg_si_q <= 2'h0;
      end else begin
         pg_cnt_q <= (cap && !burst_mode) ? 3'h0 : (pg_load ? pg_cnt_q + 3'h1 : pg_cnt_q);
         pg_sv_q <= pg_load & ~burst_mode;
         pg_si_q <= pg_cnt_q[1:0];
      end
   end

   // Array word is sampled one clock after its address is registered
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         for (int w = 0; w < PAGE_WORDS; w++) page_q[w] <= '0;
      end else if (pg_sv_q) begin
         page_q[pg_si_q] <= arr_data;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Burst sequencer
   fbo_burst_t bst_q, bst_d;
   logic [ADDR_W-1:0] bstart_q, bidx_q, bidx_d, cur_addr;
   logic [2:0] lat_cnt_q, lat_cnt_d;
   logic [1:0] wcnt_q, wcnt_d;
   logic emit, last, need_wait;
   assign cur_addr = seq_addr(bstart_q, bidx_q, blen, ilv);
   assign last = (blen == BURST_LEN_4) ? (bidx_q == 21'd4) : ((blen == BURST_LEN_8) ? (bidx_q == 21'd8) : 1'b0);
   // Delay on a 32-word crossing grows with the start offset inside its 4-word group
   assign need_wait = cont_lin && (cur_addr[BOUNDARY_BITS-1:0] == '0) && (bidx_q != '0)
                      && (bstart_q[1:0] != 2'h0);

   always_comb begin
      bst_d = bst_q;
      bidx_d = bidx_q;
      lat_cnt_d = lat_cnt_q;
      wcnt_d = wcnt_q;
      emit = 1'b0;
      if (cap && burst_mode) begin
         bst_d = BS_LAT;
         lat_cnt_d = 3'h1;
         bidx_d = '0;
      end else if (k_edge) begin
         unique case (bst_q)
            BS_IDLE, BS_DONE: begin
            end
            BS_LAT: begin
               if (lat_cnt_q + 3'h1 >= lat) begin
                  emit = 1'b1;
                  bst_d = BS_DATA;
               end else lat_cnt_d = lat_cnt_q + 3'h1;
            end
            BS_DATA: begin
               if (last) bst_d = BS_DONE;
               else if (need_wait) begin
                  bst_d = BS_WAIT;
                  wcnt_d = bstart_q[1:0];
               end else emit = 1'b1;
            end
            BS_WAIT: begin
               if (wcnt_q == 2'h1) begin
                  emit = 1'b1;
                  bst_d = BS_DATA;
               end else wcnt_d = wcnt_q - 2'h1;
            end
         endcase
      end
      if (emit) bidx_d = bidx_q + 21'd1;
      if (ce_n_s || !rp_n_s) bst_d = BS_IDLE;
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         bst_q <= BS_IDLE;
         bidx_q <= '0;
         lat_cnt_q <= 3'h0;
         wcnt_q <= 2'h0;
         bstart_q <= '0;
      end else begin
         bst_q <= bst_d;
         bidx_q <= bidx_d;
         lat_cnt_q <= lat_cnt_d;
         wcnt_q <= wcnt_d;
         if (cap) bstart_q <= pin_addr;
      end
   end

   // Array address: page fill in page mode, next burst word in burst mode
   always_ff @(posedge clk) begin
      if (sys_rst) arr_addr <= '0;
      else if (burst_mode) arr_addr <= cur_addr;
      else arr_addr <= {addr_q[ADDR_W-1:2], pg_cnt_q[1:0]};
   end

   ////////////////////////////////////////////////////////////////////////////
   // Output drivers
   logic drive;
   logic inv;
   assign drive = rp_n_s & ~ce_n_s & ~oe_n_s;
   assign inv = bus_inversion_flag_en && (ones(rd_word ^ muxed_addr_data_bus_out) > 5'd8);

   // Burst output changes only on emitted words; page output follows the address
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         muxed_addr_data_bus_out <= '0;
         muxed_addr_data_bus_oe <= 1'b0;
         bus_inversion_flag_out <= 1'b0;
         bus_inversion_flag_oe <= 1'b0;
         wait_out <= 1'b0;
         wait_oe <= 1'b0;
      end else begin
         if (!burst_mode) begin
            muxed_addr_data_bus_out <= rd_word;
            bus_inversion_flag_out <= 1'b0;
         end else if (emit) begin
            muxed_addr_data_bus_out <= inv ? ~rd_word : rd_word;
            bus_inversion_flag_out <= inv;
         end
         muxed_addr_data_bus_oe <= drive;
         bus_inversion_flag_oe <= drive;
         wait_out <= burst_mode & (bst_d == BS_WAIT);
         wait_oe <= drive;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Write capture: ends when either enable rises
   logic wr_act, wr_act_q;
   logic [DATA_W-1:0] wdat_q;
   assign wr_act = rp_n_s & ~ce_n_s & ~we_n_s & oe_n_s;

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         wr_act_q <= 1'b0;
         wdat_q <= '0;
         wr_strobe <= 1'b0;
         wr_addr <= '0;
         wr_data <= '0;
      end else begin
         wr_act_q <= wr_act;
         if (wr_act) wdat_q <= (bus_inversion_flag_en & bus_inversion_flag_s) ? ~bus_s : bus_s;
         wr_strobe <= wr_act_q & ~wr_act;
         if (wr_act_q && !wr_act) begin
            wr_addr <= addr_q;
            wr_data <= wdat_q;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Power states; idle counter saturates so it never wraps
   logic [7:0] idle_q;
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         idle_q <= 8'h00;
         standby <= 1'b1;
         pseudo_standby <= 1'b0;
         powerdown <= 1'b0;
      end else begin
         if (syn != syn_p_q || burst_mode || ce_n_s) idle_q <= 8'h00;
         else if (idle_q < 8'(AUTO_STANDBY_CYC)) idle_q <= idle_q + 8'h01;
         pseudo_standby <= ~burst_mode & ~ce_n_s & (idle_q == 8'(AUTO_STANDBY_CYC));
         standby <= ce_n_s & ~pe_busy;
         powerdown <= pdn_en & ~rp_n_s;
      end
   end

   assign cfg_value = cfg_q;
endmodule // fbo_flash_bus_ops

/* File: fbo_bus_ops_monitor.sv */
// Concurrent checks on the pins and result pulses of the flash bus-operation block
`timescale 1ns/1ps
module fbo_bus_ops_monitor
   import fbo_pkg::*;
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic chip_en_n,
   input wire logic out_en_n,
   input wire logic wr_en_n,
   input wire logic hard_reset_pwrdn_n,
   input wire logic write_guard_n,
   input wire logic muxed_addr_data_bus_oe,
   input wire logic bus_inversion_flag_oe,
   input wire logic wait_oe,
   input wire logic cfg_wr,
   input wire logic [fbo_pkg::CFG_W-1:0] cfg_wdata,
   input wire logic [fbo_pkg::CFG_W-1:0] cfg_value,
   input wire logic blk_unprotect,
   input wire logic pe_req,
   input wire logic pe_grant,
   input wire logic pe_refused,
   input wire logic unprot_refused,
   input wire logic wr_strobe,
   input wire logic standby,
   input wire logic pseudo_standby,
   input wire logic powerdown
);
   ////////////////////////////////////////////////////////////////////////////
   // Pin effects land three clocks late, behind the synchronisers and one register
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   a_read_drive_gate: assert property (muxed_addr_data_bus_oe |-> !$past(chip_en_n, 3) && !$past(out_en_n, 3))
      else $error("bus driven without both enables");
   a_standby_float: assert property (standby |-> !muxed_addr_data_bus_oe && !wait_oe)
      else $error("outputs driven in standby");
   a_pd_float: assert property (powerdown |-> !muxed_addr_data_bus_oe && !bus_inversion_flag_oe)
      else $error("outputs driven in power-down");
   a_pd_allowed: assert property (powerdown |-> cfg_value[CFG_POWERDOWN_ALLOW_BIT] && !$past(hard_reset_pwrdn_n, 3))
      else $error("power-down without allow bit and low pin");
   a_cfg_load: assert property (cfg_wr && $past(hard_reset_pwrdn_n, 2) && $past(hard_reset_pwrdn_n, 3)
      |=> cfg_value == $past(cfg_wdata))
      else $error("config word not loaded");
   a_rp_defaults: assert property (!$past(hard_reset_pwrdn_n, 3) |-> cfg_value[15] && !cfg_value[14])
      else $error("mode bits not restored by reset pin");
   a_pe_answer: assert property (pe_req |=> pe_grant != pe_refused)
      else $error("program check gave no single answer");
   a_pe_cause: assert property ((pe_grant || pe_refused) |-> $past(pe_req))
      else $error("program answer without request");
   a_unprot_guard: assert property (unprot_refused |-> $past(blk_unprotect) && !$past(write_guard_n, 3))
      else $error("unprotect refused with guard released");
   a_pseudo_page: assert property (pseudo_standby |-> cfg_value[CFG_READ_MODE_SELECT_BIT])
      else $error("pseudo-standby outside page mode");
   a_write_end: assert property (wr_strobe |-> $past(wr_en_n, 3) || $past(chip_en_n, 3))
      else $error("write taken before an enable rose");
   // Main scenarios reached
   cover property (wr_strobe);
   cover property (unprot_refused);
   cover property (powerdown);
   cover property (pseudo_standby);
endmodule // fbo_bus_ops_monitor

/* File: fbo_array_model.sv */
// Behavioural array behind the block, answering within the cycle of the address
`timescale 1ns/1ps
module fbo_array_model
   import fbo_pkg::*;
(
   input wire logic [fbo_pkg::ADDR_W-1:0] arr_addr,
   output logic [fbo_pkg::DATA_W-1:0] arr_data
);
   // Contents derive from the address so every word is predictable without storage;
   // the block samples the word one clock after it registers the address
   always_comb begin
      arr_data = arr_addr[15:0] ^ {arr_addr[20:16], 11'h0A5};
   end
endmodule // fbo_array_model

/* File: fbo_flash_bus_ops_bench.sv */
// Self-checking bench for the flash bus-operation block
`timescale 1ns/1ps
module fbo_flash_bus_ops_bench;
   import fbo_pkg::*;
   localparam logic [15:0] MAKER = 16'h0B17; // Arbitrary value
   localparam logic [15:0] PART = 16'h0C28; // Arbitrary value
   logic clk = 1'b0, sys_rst = 1'b1, chip_en_n = 1'b1, out_en_n = 1'b1, wr_en_n = 1'b1, latch_en_n = 1'b1;
   logic burst_clk = 1'b0, hard_reset_pwrdn_n = 1'b1, write_guard_n = 1'b1, bus_inversion_flag_in = 1'b0;
   logic id_mode = 1'b0, pe_busy = 1'b0, pe_bank = 1'b0, cfg_wr = 1'b0, pe_req = 1'b0;
   logic blk_protect = 1'b0, blk_unprotect = 1'b0, blk_lock = 1'b0;
   logic [4:0] upper_address_lines = 5'h00;
   logic [15:0] muxed_addr_data_bus_in = 16'h0000, status_word = 16'h5A3C, cfg_wdata = 16'h0000;
   logic [15:0] muxed_addr_data_bus_out, arr_data, wr_data, cfg_value, d;
   logic [20:0] arr_addr, wr_addr, a;
   logic muxed_addr_data_bus_oe, bus_inversion_flag_out, bus_inversion_flag_oe, wait_out, wait_oe;
   logic pe_grant, pe_refused, unprot_refused, wr_strobe, standby, pseudo_standby, powerdown;
   logic [36:0] wq[$];
   logic [2:0] bq[$];
   logic [36:0] wn;
   logic [2:0] bn;
   int fail_count = 0, check_count = 0;
   integer seed = 32'h2578;
   always #4 clk = ~clk;
   fbo_flash_bus_ops #(.MAKER_CODE(MAKER), .PART_CODE(PART)) i_dut (.clk, .sys_rst, .chip_en_n, .out_en_n,
      .wr_en_n, .latch_en_n, .burst_clk, .hard_reset_pwrdn_n, .write_guard_n, .upper_address_lines,
      .muxed_addr_data_bus_in, .muxed_addr_data_bus_out, .muxed_addr_data_bus_oe, .bus_inversion_flag_in,
      .bus_inversion_flag_out, .bus_inversion_flag_oe, .wait_out, .wait_oe, .arr_addr, .arr_data, .id_mode,
      .pe_busy, .pe_bank, .status_word, .cfg_wr, .cfg_wdata, .cfg_value, .blk_protect, .blk_unprotect,
      .blk_lock, .pe_req, .pe_grant, .pe_refused, .unprot_refused, .wr_strobe, .wr_addr, .wr_data, .standby,
      .pseudo_standby, .powerdown);
   fbo_array_model i_arr (.arr_addr, .arr_data);
   ////////////////////////////////////////////////////////////////////////////
   // Helpers; stimulus always moves on the falling edge
   function automatic logic [15:0] mem(input logic [20:0] x);
      return x[15:0] ^ {x[20:16], 11'h0A5};
   endfunction
   task automatic tick(input int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic chk_val(input string n, input logic [20:0] e, input logic [20:0] g);
      check_count++;
      if (g !== e) begin
         $display("wrong value %s expected %h seen %h", n, e, g);
         fail_count++;
      end
   endtask
   task automatic chk_flag(input string n, input logic e, input logic g);
      chk_val(n, {20'h0, e}, {20'h0, g});
   endtask
   task automatic close_out;
      chk_val("pending", 21'h0, 21'(wq.size() + bq.size()));
      if (fail_count == 0 && check_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task automatic put_addr(input logic [20:0] x);
      chip_en_n = 1'b0;
      latch_en_n = 1'b0;
      {upper_address_lines, muxed_addr_data_bus_in} = x;
      tick(4);
      latch_en_n = 1'b1;
      tick(3);
      // Address held until the synchronised latch rise has sampled it
      muxed_addr_data_bus_in = ~x[15:0];
      tick(1);
   endtask
   // Read with w idle clocks; the released bus shows the inverse so stale values cannot pass
   task automatic rd(input logic [20:0] x, input logic [15:0] e, input int w, input logic p);
      put_addr(x);
      out_en_n = 1'b0;
      tick(w);
      chk_flag("bus_oe", 1'b1, muxed_addr_data_bus_oe);
      chk_flag("pseudo_standby", p, pseudo_standby);
      chk_val("read", {5'h00, e}, {5'h00, muxed_addr_data_bus_out});
      out_en_n = 1'b1;
      tick(4);
      chk_flag("bus_oe", 1'b0, muxed_addr_data_bus_oe);
      chip_en_n = 1'b1;
      tick(4);
   endtask
   task automatic st(input logic [15:0] e);
      rd({a[20:8], ID_BLOCK_ADDR}, e, 14, 1'b0);
   endtask
   task automatic wr(input logic [20:0] x, input logic [15:0] v, input logic by_ce);
      put_addr(x);
      muxed_addr_data_bus_in = v;
      wr_en_n = 1'b0;
      tick(4);
      wq.push_back({x, v});
      if (by_ce)
         chip_en_n = 1'b1;
      else
         wr_en_n = 1'b1;
      tick(1);
      muxed_addr_data_bus_in = ~v;
      wr_en_n = 1'b1;
      chip_en_n = 1'b1;
      tick(6);
   endtask
   task automatic cmd(input logic [3:0] m, input logic [2:0] e);
      {blk_protect, blk_unprotect, blk_lock, pe_req} = m;
      if (e != 3'h0)
         bq.push_back(e);
      tick(1);
      {blk_protect, blk_unprotect, blk_lock, pe_req} = 4'h0;
      tick(3);
   endtask
   task automatic cfgw(input logic [15:0] v);
      cfg_wdata = v;
      cfg_wr = 1'b1;
      tick(1);
      cfg_wr = 1'b0;
      tick(1);
      chk_val("cfg_value", {5'h00, v}, {5'h00, cfg_value});
   endtask
   // Capture on the chosen edge, then one word per active edge after the latency
   task automatic burst(input logic [15:0] cfg, input logic [20:0] x, input int lat, input int len);
      logic pol;
      logic [20:0] ea;
      int i;
      pol = cfg[CFG_CLK_EDGE_BIT];
      cfgw(cfg);
      burst_clk = ~pol;
      chip_en_n = 1'b0;
      latch_en_n = 1'b0;
      {upper_address_lines, muxed_addr_data_bus_in} = x;
      tick(4);
      burst_clk = pol;
      latch_en_n = 1'b1;
      out_en_n = 1'b0;
      for (int k = 1; k <= 10; k++) begin
         tick(4);
         muxed_addr_data_bus_in = ~x[15:0];
         burst_clk = ~pol;
         tick(4);
         burst_clk = pol;
         tick(5);
         i = (k - lat + 1 < len) ? k - lat + 1 : len - 1;
         ea = cfg[CFG_BURST_ORDER_BIT] ? x ^ 21'(i) : x + 21'(i);
         if (i >= 0)
            chk_val("burst_word", {5'h00, mem(ea)}, {5'h00, muxed_addr_data_bus_out});
         chk_flag("wait_out", 1'b0, wait_out);
      end
      chip_en_n = 1'b1;
      out_en_n = 1'b1;
      tick(6);
   endtask
   ////////////////////////////////////////////////////////////////////////////
   // Each result pulse retires the oldest note of its kind
   always @(negedge clk) begin
      if (wr_strobe === 1'b1) begin
         wn = (wq.size() > 0) ? wq.pop_front() : 37'h0;
         chk_val("wr_addr", wn[36:16], wr_addr);
         chk_val("wr_data", {5'h00, wn[15:0]}, {5'h00, wr_data});
      end
      if ((pe_grant | pe_refused | unprot_refused) === 1'b1) begin
         bn = (bq.size() > 0) ? bq.pop_front() : 3'h0;
         chk_val("block_answer", {18'h0, bn}, {18'h0, pe_grant, pe_refused, unprot_refused});
      end
   end
   // Cuts a hang short well beyond the expected run length
   initial begin
      #(8 * 30000);
      fail_count++;
      close_out();
   end
   initial begin
      tick(20);
      sys_rst = 1'b0;
      tick(4);
      chk_val("cfg_value", {5'h00, CFG_RESET}, {5'h00, cfg_value});
      chk_flag("standby", 1'b1, standby);
      rd(21'h01230B, mem(21'h01230B), 30, 1'b1);
      pe_busy = 1'b1;
      pe_bank = 1'b1;
      rd(21'h0A0004, status_word, 14, 1'b0);
      rd(21'h010006, mem(21'h010006), 14, 1'b0);
      chk_flag("standby", 1'b0, standby);
      pe_busy = 1'b0;
      a = {6'($random(seed)), 15'($random(seed))};
      d = 16'($random(seed));
      wr(a ^ 21'h000010, ~d, 1'b1);
      wr(a, d, 1'b0);
      id_mode = 1'b1;
      rd({13'($random(seed)), ID_MAKER_ADDR}, MAKER, 14, 1'b0);
      rd({13'($random(seed)), ID_PART_ADDR}, PART, 14, 1'b0);
      cmd(4'h1, 3'b010);
      st(16'h0001);
      cmd(4'h4, 3'h0);
      st(16'h0000);
      cmd(4'h1, 3'b100);
      cmd(4'h2, 3'h0);
      st(16'h0002);
      cmd(4'h1, 3'b100);
      write_guard_n = 1'b0;
      tick(4);
      cmd(4'h1, 3'b010);
      cmd(4'h8, 3'h0);
      st(16'h0003);
      cmd(4'h4, 3'b001);
      write_guard_n = 1'b1;
      tick(4);
      cmd(4'h4, 3'h0);
      st(16'h0002);
      id_mode = 1'b0;
      burst(16'h1041, 21'h012340, 2, 4);
      burst(16'h1882, 21'h012345, 3, 8);
      burst(16'h3040, 21'h000100, 6, 99);
      cfgw(16'h5400);
      chip_en_n = 1'b0;
      out_en_n = 1'b0;
      hard_reset_pwrdn_n = 1'b0;
      tick(6);
      chk_flag("powerdown", 1'b1, powerdown);
      chk_flag("bus_oe", 1'b0, muxed_addr_data_bus_oe);
      hard_reset_pwrdn_n = 1'b1;
      chip_en_n = 1'b1;
      out_en_n = 1'b1;
      tick(6);
      chk_val("cfg_value", 21'h009400, {5'h00, cfg_value});
      id_mode = 1'b1;
      st(16'h0001);
      cfgw(16'h9000);
      hard_reset_pwrdn_n = 1'b0;
      tick(6);
      chk_flag("powerdown", 1'b0, powerdown);
      hard_reset_pwrdn_n = 1'b1;
      tick(6);
      close_out();
   end
endmodule // fbo_flash_bus_ops_bench
bind fbo_flash_bus_ops fbo_bus_ops_monitor i_mon (.clk, .sys_rst, .chip_en_n, .out_en_n, .wr_en_n,
   .hard_reset_pwrdn_n, .write_guard_n, .muxed_addr_data_bus_oe, .bus_inversion_flag_oe, .wait_oe, .cfg_wr,
   .cfg_wdata, .cfg_value, .blk_unprotect, .pe_req, .pe_grant, .pe_refused, .unprot_refused, .wr_strobe,
   .standby, .pseudo_standby, .powerdown);
